// ===== rwic_checker_assertions.sv
// Purpose: port-level checks of the reset, wake and interrupt controller
// Assumes: bound to rwic_top; counts handed on from the instance
// Notes:   hold length is measured by a helper counter, not a long repetition
`timescale 1ns/1ps
module rwic_checker #(parameter int START_CYCLES = 20, parameter int PC_W = 10) (
    input wire logic            MCLK, RESET_N, RST_PIN_N, WDT_TICK, // clock, resets, tick
    input wire logic            SLEEP_INSTR, CLR_WDT_INSTR,        // instruction strobes
    input wire logic            CORE_RESET, PORTS_INPUT, WDT_CLR,  // hold outputs
    input wire logic            SLEEPING, PC_LOAD, IRQ_REQ, GIE,   // core control
    input wire logic            STAT_T, STAT_P,                    // status flags
    input wire logic [PC_W-1:0] PC_TARGET,                         // pc load value
    input wire logic [7:0]      TMR_CTRL, PULL_HI, PULL_DN, OPEN_DR, // port setup
    input wire logic [7:0]      WDT_CTRL, IRQ_FLAGS, IRQ_MASK      // wdt and irq regs
);
    int hold_cnt_reg; // cycles spent in the current hold
    // count hold cycles; cleared when running so every hold is timed on its own
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) hold_cnt_reg <= 0;
        else hold_cnt_reg <= CORE_RESET ? hold_cnt_reg + 1 : 0;
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    AST_PIN_RST: assert property (!RST_PIN_N |=> CORE_RESET)
        else $error("pin low did not hold the core");
    AST_HOLD_LEN: assert property ($fell(CORE_RESET) |-> hold_cnt_reg >= START_CYCLES)
        else $error("hold released too early");
    AST_WDT_CLR: assert property (CORE_RESET |-> WDT_CLR)
        else $error("watchdog not cleared in hold");
    AST_PORTS_IN: assert property (CORE_RESET |-> PORTS_INPUT)
        else $error("ports not forced to input in hold");
    AST_PORT_CFG: assert property (CORE_RESET && $past(CORE_RESET) |->
        TMR_CTRL == 8'hBF && PULL_HI == 8'hFF && PULL_DN == 8'h00 && OPEN_DR == 8'hFF)
        else $error("port setup registers wrong in hold");
    AST_IRQ_CFG: assert property (CORE_RESET && $past(CORE_RESET) |->
        WDT_CTRL[7:6] == 2'b10 && IRQ_FLAGS[6:0] == 7'h00 && IRQ_MASK[6:0] == 7'h00)
        else $error("watchdog or irq registers wrong in hold");
    AST_GATE: assert property (IRQ_REQ == |(IRQ_FLAGS[6:0] & IRQ_MASK[6:0]))
        else $error("request is not flags and mask");
    AST_VECTOR: assert property (GIE && IRQ_REQ && !CORE_RESET && !SLEEPING
        && RST_PIN_N && !WDT_TICK |=> PC_LOAD && PC_TARGET == 8 && !GIE)
        else $error("enabled request did not vector");
    AST_SLEEP: assert property (SLEEP_INSTR && !CORE_RESET && !SLEEPING
        && RST_PIN_N && !WDT_TICK |=> SLEEPING && STAT_T && !STAT_P)
        else $error("sleep entry wrong");
    AST_CLR_TP: assert property (CLR_WDT_INSTR && !CORE_RESET && !SLEEPING
        && RST_PIN_N && !WDT_TICK |=> STAT_T && STAT_P)
        else $error("clear watchdog did not set flags");
    COV_VEC: cover property (PC_LOAD && PC_TARGET == 8);
    COV_WAKE: cover property ($fell(SLEEPING) && !CORE_RESET);
    COV_REHOLD: cover property ($rose(CORE_RESET));
endmodule // rwic_checker
bind rwic_top rwic_checker #(.START_CYCLES(START_CYCLES), .PC_W(PC_W)) u_chk (.*);

// ===== rwic_pkg.sv
// Purpose: shared constants for the reset, wake-up and interrupt controller
// Assumes: 20 MHz MCLK, 8-bit core registers
// Notes:   register select codes are used by the plain register write port
package rwic_pkg;
    localparam int          MCLK_HZ       = 20000000;    // core clock rate
    localparam int          START_MS      = 18;          // start-up hold time, ms
    localparam int          START_CYC     = (START_MS * (MCLK_HZ / 1000));
    localparam int          WDT_TICKS_DEF = 256;         // watchdog ticks to time-out
    localparam int          PC_W_DEF      = 10;          // program counter width
    localparam int          DW            = 8;           // register width
    localparam int          IRQ_N         = 7;           // flag bits 0..6
    localparam logic [2:0]  SEL_TMR_CTRL  = 3'h0;        // timer control
    localparam logic [2:0]  SEL_PULL_HI   = 3'h1;        // pull-high control
    localparam logic [2:0]  SEL_PULL_DN   = 3'h2;        // pull-down control
    localparam logic [2:0]  SEL_OPEN_DR   = 3'h3;        // open-drain control
    localparam logic [2:0]  SEL_WDT_CTRL  = 3'h4;        // watchdog control
    localparam logic [2:0]  SEL_FLAG      = 3'h5;        // interrupt flags
    localparam logic [2:0]  SEL_MASK      = 3'h6;        // interrupt mask
    localparam logic [2:0]  SEL_STAT_HI   = 3'h7;        // status upper three bits
    localparam logic [7:0]  TMR_CTRL_RST  = 8'hBF;       // all ones but edge flag
    localparam logic [7:0]  PULL_HI_RST   = 8'hFF;
    localparam logic [7:0]  PULL_DN_RST   = 8'h00;
    localparam logic [7:0]  OPEN_DR_RST   = 8'hFF;
    localparam logic [7:0]  WDT_CTRL_RST  = 8'h80;       // enable set, bit six clear
    localparam int          WDT_EN_BIT    = 7;           // watchdog enable
    localparam int          WDT_B6_BIT    = 6;           // cleared on reset
    localparam logic [6:0]  IRQ_LOW_RST   = 7'h00;       // flag/mask bits 0..6
    localparam logic [2:0]  STAT_HI_RST   = 3'h0;
    localparam int          F_TMR         = 0;           // main timer overflow
    localparam int          F_PCHG        = 1;           // port 6 change
    localparam int          F_EXT         = 2;           // external irq pin
    localparam int          F_ADC         = 3;           // converter done
    localparam int          F_PWM1        = 4;           // pwm timer one period
    localparam int          F_PWM2        = 5;           // pwm timer two period
    localparam int          F_CMP         = 6;           // comparator change
    localparam int          VEC_RESET     = 0;           // reset vector
    localparam int          VEC_IRQ       = 8;           // hardware interrupt vector
    localparam int          VEC_SWI       = 1;           // software interrupt vector
endpackage

// ===== rwic_top.sv
// Purpose: reset sources, start-up hold, sleep/wake and interrupt gating
// Assumes: all inputs synchronous to MCLK; instruction strobes are 1-cycle pulses
// Notes:   watchdog oscillator arrives as a one-cycle tick strobe
`timescale 1ns/1ps
module rwic_top #(
    parameter int START_CYCLES = rwic_pkg::START_CYC,     // start-up hold length
    parameter int WDT_TICKS    = rwic_pkg::WDT_TICKS_DEF, // watchdog time-out ticks
    parameter int PC_W         = rwic_pkg::PC_W_DEF       // program counter width
) (
    input  wire logic                    MCLK,           // core clock
    input  wire logic                    RESET_N,        // power-on reset, low
    input  wire logic                    RST_PIN_N,      // external reset pin, low
    input  wire logic                    WDT_TICK,       // watchdog oscillator tick
    input  wire logic                    CLR_WDT_INSTR,  // clear-watchdog executed
    input  wire logic                    SLEEP_INSTR,    // sleep executed
    input  wire logic                    IRQ_ON_INSTR,   // global enable on
    input  wire logic                    IRQ_OFF_INSTR,  // global enable off
    input  wire logic                    IRQ_RET_INSTR,  // return from handler
    input  wire logic                    SW_IRQ_INSTR,   // software interrupt
    input  wire logic                    TIMER_OVF,      // main timer overflow pulse
    input  wire logic                    EXT_IRQ_EVT,    // external pin edge pulse
    input  wire logic                    ADC_DONE,       // converter done pulse
    input  wire logic                    PWM1_MATCH,     // pwm one period pulse
    input  wire logic                    PWM2_MATCH,     // pwm two period pulse
    input  wire logic                    CMP_OUT,        // comparator output level
    input  wire logic [7:0]              PORT6_IN,       // port 6 pin levels
    input  wire logic [7:0]              PORT6_IS_IN,    // port 6 pin is input
    input  wire logic                    PORT6_READ,     // software read of port 6
    input  wire logic                    REG_WR,         // register write strobe
    input  wire logic [2:0]              REG_SEL,        // register select
    input  wire logic [7:0]              REG_WDATA,      // register write data
    output logic                         CORE_RESET,     // core held in reset
    output logic                         PORTS_INPUT,    // force ports to input
    output logic                         SLEEPING,       // power-down mode
    output logic                         WDT_CLR,        // watchdog/prescaler clear
    output logic                         PC_LOAD,        // load pc pulse
    output logic [PC_W-1:0]              PC_TARGET,      // pc value to load
    output logic                         IRQ_REQ,        // gated interrupt request
    output logic                         GIE,            // global interrupt enable
    output logic                         STAT_T,         // timeout flag
    output logic                         STAT_P,         // powerdown flag
    output logic [2:0]                   STAT_HI,        // status upper bits
    output logic [7:0]                   TMR_CTRL,       // timer control register
    output logic [7:0]                   PULL_HI,        // pull-high control
    output logic [7:0]                   PULL_DN,        // pull-down control
    output logic [7:0]                   OPEN_DR,        // open-drain control
    output logic [7:0]                   WDT_CTRL,       // watchdog control register
    output logic [7:0]                   IRQ_FLAGS,      // interrupt flag register
    output logic [7:0]                   IRQ_MASK        // interrupt mask register
);
    typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP} rwic_state_t;
    logic [1:0]       sync_reg;        // reset release synchroniser
    logic             rst_n;           // synchronised reset
    rwic_state_t      state_reg;       // controller state
    logic [31:0]      hold_cnt_reg;    // start-up hold counter
    logic [31:0]      wdt_cnt_reg;     // watchdog tick counter
    logic             por_reg;         // this hold came from power-on
    logic             t_reg;           // timeout flag
    logic             p_reg;           // powerdown flag
    logic             gie_reg;         // global enable
    logic             pc_load_reg;     // pc load pulse
    logic [PC_W-1:0]  pc_reg;          // pc target
    logic [7:0]       tmr_reg;         // timer control
    logic [7:0]       ph_reg;          // pull-high
    logic [7:0]       pd_reg;          // pull-down
    logic [7:0]       od_reg;          // open-drain
    logic [7:0]       wdt_reg;         // watchdog control
    logic [7:0]       flag_reg;        // interrupt flags
    logic [7:0]       mask_reg;        // interrupt mask
    logic [2:0]       shi_reg;         // status upper bits
    logic [7:0]       p6_ref_reg;      // port 6 snapshot from last read
    logic             cmp_q_reg;       // comparator previous level
    logic             hold;            // in reset hold
    logic             hold_done;       // hold period over
    logic             pin_rst;         // reset pin asserted
    logic             wdt_en;          // watchdog enabled
    logic             wdt_to;          // watchdog time-out
    logic             rst_evt;         // new reset source
    logic             p6_chg;          // port 6 input changed
    logic             wake;            // resume-type wake
    logic             irq_take;        // hardware interrupt accepted
    logic             swi_take;        // software interrupt accepted
    logic [7:0]       flag_set;        // hardware flag set vector
    // write hit on a selected register
    function automatic logic wr_hit(input logic [2:0] sel);
        return REG_WR && (REG_SEL == sel);
    endfunction
    // trunc an int vector address to the pc width
    function automatic logic [PC_W-1:0] vec(input int v);
        return PC_W'(v);
    endfunction
    // reset release through two flops; only stage two is read
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync_reg <= 2'h0;
        end else begin
            sync_reg <= {sync_reg[0], 1'b1};
        end
    end
    assign rst_n = sync_reg[1];
    assign hold      = (state_reg == ST_HOLD);
    assign hold_done = hold && !pin_rst && (hold_cnt_reg == 32'(START_CYCLES - 1));
    assign pin_rst   = !RST_PIN_N;
    assign wdt_en    = wdt_reg[rwic_pkg::WDT_EN_BIT];
    // time-out counts in run and sleep alike
    assign wdt_to    = !hold && wdt_en && WDT_TICK
                       && (wdt_cnt_reg == 32'(WDT_TICKS - 1));
    assign rst_evt   = !hold && (pin_rst || wdt_to);
    // outputs are excluded; the ext irq pin sits on port 5 so never enters here
    assign p6_chg    = |((PORT6_IN ^ p6_ref_reg) & PORT6_IS_IN);
    // wakes that keep executing; pin and watchdog wakes go through rst_evt
    assign wake      = (state_reg == ST_SLEEP) && !rst_evt
                       && ((p6_chg && mask_reg[rwic_pkg::F_PCHG])
                        || (CMP_OUT && mask_reg[rwic_pkg::F_CMP])
                        || (ADC_DONE && mask_reg[rwic_pkg::F_ADC]));
    assign irq_take  = (state_reg == ST_RUN) && !rst_evt && gie_reg && IRQ_REQ;
    assign swi_take  = (state_reg == ST_RUN) && !rst_evt && gie_reg && SW_IRQ_INSTR
                       && !IRQ_REQ;
    // hardware sets; port-change flag only when its mask bit is armed
    always_comb begin
        flag_set = 8'h00;
        flag_set[rwic_pkg::F_TMR]  = TIMER_OVF;
        flag_set[rwic_pkg::F_PCHG] = p6_chg && mask_reg[rwic_pkg::F_PCHG];
        flag_set[rwic_pkg::F_EXT]  = EXT_IRQ_EVT;
        flag_set[rwic_pkg::F_ADC]  = ADC_DONE;
        flag_set[rwic_pkg::F_PWM1] = PWM1_MATCH;
        flag_set[rwic_pkg::F_PWM2] = PWM2_MATCH;
        flag_set[rwic_pkg::F_CMP]  = CMP_OUT ^ cmp_q_reg;
    end
    // main state: hold, run, sleep
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_HOLD;
        end else begin
            unique case (state_reg)
                ST_HOLD: if (hold_done) state_reg <= ST_RUN;
                ST_RUN: begin
                    if (rst_evt) state_reg <= ST_HOLD;
                    else if (SLEEP_INSTR) state_reg <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (rst_evt) state_reg <= ST_HOLD;
                    else if (wake) state_reg <= ST_RUN;
                end
            endcase
        end
    end
    // hold counter restarts while the pin stays low
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_reg <= 32'h0;
        end else if (!hold || pin_rst) begin
            hold_cnt_reg <= 32'h0;
        end else if (!hold_done) begin
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
        end
    end
    // power-on marker, dropped once the first hold ends
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            por_reg <= 1'b1;
        end else if (hold_done) begin
            por_reg <= 1'b0;
        end
    end
    // watchdog counter; cleared by hold, clear instruction, time-out and sleep entry with the watchdog enabled
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            wdt_cnt_reg <= 32'h0;
        end else if (WDT_CLR || wdt_to) begin
            wdt_cnt_reg <= 32'h0;
        end else if (wdt_en && WDT_TICK) begin
            wdt_cnt_reg <= wdt_cnt_reg + 32'h1;
        end
    end
    assign WDT_CLR = hold || ((state_reg == ST_RUN)
                     && (CLR_WDT_INSTR || (SLEEP_INSTR && wdt_en)));
    // timeout and powerdown flags; async reset is the power-on case
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            t_reg <= 1'b1;
            p_reg <= 1'b1;
        end else if (rst_evt && pin_rst) begin
            if (state_reg == ST_SLEEP) begin
                t_reg <= 1'b1;
                p_reg <= 1'b0;
            end
        end else if (rst_evt) begin
            t_reg <= 1'b0;
            if (state_reg == ST_SLEEP) p_reg <= 1'b0;
        end else if (wake) begin
            t_reg <= 1'b1;
            p_reg <= 1'b0;
        end else if ((state_reg == ST_RUN) && CLR_WDT_INSTR) begin
            t_reg <= 1'b1;
            p_reg <= 1'b1;
        end else if ((state_reg == ST_RUN) && SLEEP_INSTR) begin
            t_reg <= 1'b1;
            p_reg <= 1'b0;
        end
    end
    // global enable; cleared on entry to a handler so it fires once
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            gie_reg <= 1'b0;
        end else if (hold || irq_take || swi_take || (wake && gie_reg)) begin
            gie_reg <= 1'b0;
        end else if (IRQ_ON_INSTR || IRQ_RET_INSTR) begin
            gie_reg <= 1'b1;
        end else if (IRQ_OFF_INSTR) begin
            gie_reg <= 1'b0;
        end
    end
    // pc loads: reset vector, hardware vector on enabled wake or interrupt, software vector
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pc_load_reg <= 1'b0;
            pc_reg      <= '0;
        end else begin
            pc_load_reg <= 1'b0;
            if (hold_done) begin
                pc_load_reg <= 1'b1;
                pc_reg      <= vec(rwic_pkg::VEC_RESET);
            end else if ((wake && gie_reg) || irq_take) begin
                pc_load_reg <= 1'b1;
                pc_reg      <= vec(rwic_pkg::VEC_IRQ);
            end else if (swi_take) begin
                pc_load_reg <= 1'b1;
                pc_reg      <= vec(rwic_pkg::VEC_SWI);
            end
        end
    end
    // port and timer configuration registers; hold reapplies reset values
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            tmr_reg <= rwic_pkg::TMR_CTRL_RST;
            ph_reg  <= rwic_pkg::PULL_HI_RST;
            pd_reg  <= rwic_pkg::PULL_DN_RST;
            od_reg  <= rwic_pkg::OPEN_DR_RST;
        end else if (hold) begin
            tmr_reg <= rwic_pkg::TMR_CTRL_RST;
            ph_reg  <= rwic_pkg::PULL_HI_RST;
            pd_reg  <= rwic_pkg::PULL_DN_RST;
            od_reg  <= rwic_pkg::OPEN_DR_RST;
        end else begin
            if (wr_hit(rwic_pkg::SEL_TMR_CTRL)) tmr_reg <= REG_WDATA;
            if (wr_hit(rwic_pkg::SEL_PULL_HI))  ph_reg  <= REG_WDATA;
            if (wr_hit(rwic_pkg::SEL_PULL_DN))  pd_reg  <= REG_WDATA;
            if (wr_hit(rwic_pkg::SEL_OPEN_DR))  od_reg  <= REG_WDATA;
        end
    end
    // watchdog control; a wake forces the enable back on
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            wdt_reg <= rwic_pkg::WDT_CTRL_RST;
        end else if (hold) begin
            wdt_reg[rwic_pkg::WDT_EN_BIT] <= 1'b1;
            wdt_reg[rwic_pkg::WDT_B6_BIT] <= 1'b0;
        end else if (wake) begin
            wdt_reg[rwic_pkg::WDT_EN_BIT] <= 1'b1;
        end else if (wr_hit(rwic_pkg::SEL_WDT_CTRL)) begin
            wdt_reg <= REG_WDATA;
        end
    end
    // status upper bits survive every reset but power-on
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            shi_reg <= rwic_pkg::STAT_HI_RST;
        end else if (hold && por_reg) begin
            shi_reg <= rwic_pkg::STAT_HI_RST;
        end else if (!hold && wr_hit(rwic_pkg::SEL_STAT_HI)) begin
            shi_reg <= REG_WDATA[2:0];
        end
    end
    // flags and mask; a hardware set wins over a software clear
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= 8'h00;
            mask_reg <= 8'h00;
        end else if (hold) begin
            flag_reg[rwic_pkg::IRQ_N-1:0] <= rwic_pkg::IRQ_LOW_RST;
            mask_reg[rwic_pkg::IRQ_N-1:0] <= rwic_pkg::IRQ_LOW_RST;
        end else begin
            flag_reg <= (wr_hit(rwic_pkg::SEL_FLAG) ? REG_WDATA : flag_reg)
                        | flag_set;
            if (wr_hit(rwic_pkg::SEL_MASK)) mask_reg <= REG_WDATA;
        end
    end
    // port 6 reference is taken when software reads the port
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            p6_ref_reg <= 8'h00;
            cmp_q_reg  <= 1'b0;
        end else begin
            if (PORT6_READ) p6_ref_reg <= PORT6_IN;
            cmp_q_reg <= CMP_OUT;
        end
    end
    assign CORE_RESET  = hold;
    assign PORTS_INPUT = hold;
    assign SLEEPING    = (state_reg == ST_SLEEP);
    assign PC_LOAD     = pc_load_reg;
    assign PC_TARGET   = pc_reg;
    assign IRQ_REQ     = |(flag_reg[rwic_pkg::IRQ_N-1:0] & mask_reg[rwic_pkg::IRQ_N-1:0]);
    assign GIE         = gie_reg;
    assign STAT_T      = t_reg;
    assign STAT_P      = p_reg;
    assign STAT_HI     = shi_reg;
    assign TMR_CTRL    = tmr_reg;
    assign PULL_HI     = ph_reg;
    assign PULL_DN     = pd_reg;
    assign OPEN_DR     = od_reg;
    assign WDT_CTRL    = wdt_reg;
    assign IRQ_FLAGS   = flag_reg;
    assign IRQ_MASK    = mask_reg;
endmodule // rwic_top

// ===== testbench.sv
// Purpose: directed regression of the reset, wake and interrupt controller
// Assumes: short hold of 20 cycles and watchdog time-out of 4 ticks
// Notes:   inputs change on the falling edge, outputs are read there too
`timescale 1ns/1ps
module testbench;
    logic        MCLK = 1'b0, RESET_N = 1'b0, RST_PIN_N = 1'b1, CMP_OUT = 1'b0, REG_WR = 1'b0;
    logic [12:0] ev = '0; // strobes: instructions, events, tick, port read
    logic [7:0]  PORT6_IN = 8'h00, PORT6_IS_IN = 8'hFF, REG_WDATA = 8'h00;
    logic [2:0]  REG_SEL = 3'h0, STAT_HI;
    logic        CLR_WDT_INSTR, SLEEP_INSTR, IRQ_ON_INSTR, IRQ_OFF_INSTR, IRQ_RET_INSTR;
    logic        SW_IRQ_INSTR, TIMER_OVF, EXT_IRQ_EVT, ADC_DONE, PWM1_MATCH, PWM2_MATCH;
    logic        WDT_TICK, PORT6_READ, CORE_RESET, PORTS_INPUT, SLEEPING, WDT_CLR, PC_LOAD;
    logic        IRQ_REQ, GIE, STAT_T, STAT_P;
    logic [9:0]  PC_TARGET;
    logic [7:0]  TMR_CTRL, PULL_HI, PULL_DN, OPEN_DR, WDT_CTRL, IRQ_FLAGS, IRQ_MASK;
    int          error_cnt = 0, tests_run = 0;
    assign {PORT6_READ, WDT_TICK, PWM2_MATCH, PWM1_MATCH, ADC_DONE, EXT_IRQ_EVT, TIMER_OVF,
        SW_IRQ_INSTR, IRQ_RET_INSTR, IRQ_OFF_INSTR, IRQ_ON_INSTR, SLEEP_INSTR, CLR_WDT_INSTR} = ev;
    rwic_top #(.START_CYCLES(20), .WDT_TICKS(4)) dut (.*);
    initial forever #25 MCLK = ~MCLK;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // strobe one line for a cycle, then leave a quiet cycle
    task automatic pulse(input int b, input int n = 1);
        repeat (n) begin
            ev[b] = 1'b1;
            @(negedge MCLK);
            ev[b] = 1'b0;
            @(negedge MCLK);
        end
    endtask
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        REG_WR = 1'b1;
        REG_SEL = sel;
        REG_WDATA = d;
        @(negedge MCLK);
        REG_WR = 1'b0;
        @(negedge MCLK);
    endtask
    // the load pulse stands one cycle, so poll every cycle under a bound
    task automatic wait_pc(input logic [9:0] exp);
        int i;
        for (i = 0; i < 4 && PC_LOAD !== 1'b1; i++) @(negedge MCLK);
        if (i == 4) begin
            chk(1'b0, 1'b1);
            report_and_stop();
        end else chk(PC_TARGET, exp);
    endtask
    task automatic hold_wait(output int n);
        for (n = 0; n < 80 && CORE_RESET !== 1'b0; n++) @(negedge MCLK);
        if (n == 80) begin
            chk(1'b0, 1'b1);
            report_and_stop();
        end
    endtask
    // one interrupt source: raise, vector, clear flag, return
    task automatic irq_case(input int b, input int f);
        if (b == 13) CMP_OUT = ~CMP_OUT;
        else if (b == 14) PORT6_IN = ~PORT6_IN;
        else pulse(b);
        if (b > 12) @(negedge MCLK);
        wait_pc(10'h008);
        chk({IRQ_FLAGS[f], GIE}, 2'b10);
        if (b == 14) pulse(12);
        wr(3'h5, 8'h00);
        pulse(4);
        chk(GIE, 1'b1);
    endtask
    int src[7] = '{6, 7, 8, 9, 10, 13, 14};
    int flg[7] = '{0, 2, 3, 4, 5, 6, 1};
    initial begin
        int n;
        repeat (10) @(negedge MCLK);
        RESET_N = 1'b1;
        hold_wait(n);
        chk(n >= 20, 1'b1);
        wait_pc(10'h000);
        chk({TMR_CTRL, PULL_HI}, 16'hBFFF);
        chk({PULL_DN, OPEN_DR}, 16'h00FF);
        chk({WDT_CTRL[7:6], IRQ_FLAGS[6:0], IRQ_MASK[6:0]}, 16'h8000);
        chk({STAT_HI, STAT_T, STAT_P, GIE}, 6'b000110);
        wr(3'h7, 8'h07);
        pulse(11, 4);
        chk(CORE_RESET, 1'b1);
        hold_wait(n);
        chk({STAT_HI, STAT_T, STAT_P}, 5'b11101);
        RST_PIN_N = 1'b0;
        repeat (3) @(negedge MCLK);
        RST_PIN_N = 1'b1;
        hold_wait(n);
        chk({STAT_T, STAT_P}, 2'b01);
        pulse(0);
        chk({STAT_T, STAT_P}, 2'b11);
        pulse(6);
        chk({IRQ_FLAGS[0], IRQ_REQ}, 2'b10);
        wr(3'h5, 8'h00);
        wr(3'h6, 8'h7F);
        pulse(2);
        pulse(12);
        PORT6_IS_IN = 8'hFE;
        PORT6_IN[0] = 1'b1;
        repeat (3) @(negedge MCLK);
        chk(IRQ_FLAGS[1], 1'b0);
        for (int i = 0; i < 7; i++) irq_case(src[i], flg[i]);
        ev[5] = 1'b1;
        @(negedge MCLK);
        ev[5] = 1'b0;
        wait_pc(10'h001);
        pulse(4);
        pulse(3);
        pulse(6);
        chk({GIE, IRQ_REQ, PC_LOAD}, 3'b010);
        CMP_OUT = 1'b0;
        @(negedge MCLK);
        wr(3'h5, 8'h00);
        wr(3'h4, 8'h00);
        wr(3'h6, 8'h40);
        pulse(1);
        chk({SLEEPING, STAT_T, STAT_P}, 3'b110);
        CMP_OUT = 1'b1;
        @(negedge MCLK);
        chk({SLEEPING, WDT_CTRL[7], PC_LOAD, STAT_T, STAT_P}, 5'b01010);
        CMP_OUT = 1'b0;
        @(negedge MCLK);
        wr(3'h5, 8'h00);
        wr(3'h6, 8'h08);
        pulse(2);
        pulse(1);
        ev[8] = 1'b1;
        @(negedge MCLK);
        ev[8] = 1'b0;
        wait_pc(10'h008);
        pulse(3);
        wr(3'h5, 8'h00);
        pulse(11, 3);
        pulse(1);
        pulse(11, 3);
        chk({SLEEPING, CORE_RESET}, 2'b10);
        pulse(11);
        hold_wait(n);
        chk({STAT_T, STAT_P}, 2'b00);
        pulse(1);
        RST_PIN_N = 1'b0;
        @(negedge MCLK);
        RST_PIN_N = 1'b1;
        hold_wait(n);
        chk({STAT_T, STAT_P}, 2'b10);
        RESET_N = 1'b0;
        repeat (2) @(negedge MCLK);
        RESET_N = 1'b1;
        hold_wait(n);
        chk({STAT_HI, STAT_T, STAT_P}, 5'b00011);
        report_and_stop();
    end
endmodule // testbench
